// ---- pkg/gaem_pkg.sv ----
package gaem_pkg;
	// register offsets (port a / port b)
	localparam logic [4:0] GAEM_OFS_ADDR_A = 5'h0D;
	localparam logic [4:0] GAEM_OFS_EOS_A  = 5'h0F;
	localparam logic [4:0] GAEM_OFS_ADDR_B = 5'h1D;
	localparam logic [4:0] GAEM_OFS_EOS_B  = 5'h1F;
	// address register fields
	localparam int GAEM_SEL_BIT = 7;
	localparam int GAEM_EOI_BIT = 7;
	localparam int GAEM_DT_BIT  = 6;
	localparam int GAEM_DL_BIT  = 5;
	// bus address offsets
	localparam logic [7:0] GAEM_TALK_OFS   = 8'h40; // octal 100
	localparam logic [7:0] GAEM_LISTEN_OFS = 8'h20; // octal 40
	localparam logic [7:0] GAEM_SEC_OFS    = 8'hA0;
	localparam logic [7:0] GAEM_EOS7_MASK  = 8'h7F;
	localparam logic [7:0] GAEM_EOS8_MASK  = 8'hFF;
	localparam logic [3:0] GAEM_ICR_RESET  = 4'h8;
	localparam logic [7:0] GAEM_CMD_CHIP_RESET = 8'h02;
	localparam logic [7:0] GAEM_CMD_PON_CLEAR  = 8'h00;
	// addressing modes
	typedef enum logic [1:0] {
		GAEM_MODE_NONE = 2'b00,
		GAEM_MODE_ONE  = 2'b01,
		GAEM_MODE_TWO  = 2'b10,
		GAEM_MODE_THREE = 2'b11
	} gaem_mode_t;
	// one internal address register
	typedef struct packed {
		logic       flag;
		logic       talk_dis;
		logic       listen_dis;
		logic [4:0] addr;
	} gaem_addr_t;
	// auxiliary register a bits used here
	typedef struct packed {
		logic binary_length_select;
		logic transmit_end_with_eos;
		logic end_on_eos_received;
	} gaem_aux_t;
endpackage : gaem_pkg

// ---- verilog/gaem_match.sv ----
// What this block does
// - first register: primary or major address
// - bits 4..0 hold five-bit bus address
// - talker disable 1 blocks major talk
// - listener disable 1 blocks major listen
// - talk plus 40 hex, listen plus 20
// - select bit routes write to register
// - latch eoi with each accepted byte
// - latched eoi cleared by power-on, reset
// - talker disable 1 gates secondary talk
// - listener disable 1 gates secondary listen
// - secondary A0, minor talk 40, listen 20
// - eight-bit eos, seven or eight compare
// - listener eos match sets end flag
// - talker eos match drives eoi low
// - reset sets power-on, clears listed state
// - reset loads counter with eight
// - power-on blocks bus addressing and auxiliary commands other than pon-clear and chip reset
// - pon-clear command releases, chip reset sets
`timescale 1ns/1ps
`default_nettype none
module gaem_match
	import gaem_pkg::*;
#(
	parameter logic [4:0] PORT_BASE = 5'h00
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [4:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       aux_cmd_valid,
	input  wire logic [7:0] aux_cmd,
	input  wire logic       aux_a_wr,
	input  wire gaem_aux_t  aux_a_wdata,
	input  wire gaem_mode_t addressing_mode,
	input  wire logic       atn_cmd_valid,
	input  wire logic [7:0] bus_cmd,
	input  wire logic       byte_accepted,
	input  wire logic       eoi_line,
	input  wire logic [7:0] data_in_byte,
	input  wire logic       listener_active,
	input  wire logic       talker_active,
	input  wire logic [7:0] command_data_out_register,
	output logic            eoi_out_n,
	output logic            end_flag_set,
	output logic            talk_addressed,
	output logic            listen_addressed,
	output logic            talker_primary_addressed_state,
	output logic            listener_primary_addressed_state,
	output logic            power_on,
	output logic            aux_cmd_exec,
	output logic [3:0]      internal_counter_register
);
	gaem_addr_t first_internal_address_ff;
	gaem_addr_t second_internal_address_ff;
	logic [7:0] end_of_string_register_ff;
	gaem_aux_t  auxiliary_register_a_ff;
	logic       pon_ff;
	logic [3:0] icr_ff;
	logic       talker_primary_addressed_state_ff;
	logic       listener_primary_addressed_state_ff;
	logic       talk_ff;
	logic       listen_ff;

	// port-relative decode
	wire logic hit_addr = reg_addr == (PORT_BASE | GAEM_OFS_ADDR_A);
	wire logic hit_eos  = reg_addr == (PORT_BASE | GAEM_OFS_EOS_A);
	wire logic wr_first  = reg_wr && hit_addr && !reg_wdata[GAEM_SEL_BIT];
	wire logic wr_second = reg_wr && hit_addr && reg_wdata[GAEM_SEL_BIT];
	wire logic wr_eos    = reg_wr && hit_eos;

	// auxiliary commands; power-on blocks all but the pon ones
	wire logic aux_ok     = aux_cmd_valid && !pon_ff;
	wire logic chip_reset = aux_cmd_valid && aux_cmd == GAEM_CMD_CHIP_RESET;
	wire logic pon_clear  = aux_cmd_valid && aux_cmd == GAEM_CMD_PON_CLEAR;

	wire logic [7:0] major_talk   = GAEM_TALK_OFS + {3'h0, first_internal_address_ff.addr};
	wire logic [7:0] major_listen = GAEM_LISTEN_OFS + {3'h0, first_internal_address_ff.addr};
	wire logic [7:0] minor_talk   = GAEM_TALK_OFS + {3'h0, second_internal_address_ff.addr};
	wire logic [7:0] minor_listen = GAEM_LISTEN_OFS + {3'h0, second_internal_address_ff.addr};
	wire logic [7:0] sec_addr     = GAEM_SEC_OFS + {3'h0, second_internal_address_ff.addr};
	wire logic dual = addressing_mode == GAEM_MODE_ONE || addressing_mode == GAEM_MODE_THREE;
	wire logic ext  = addressing_mode == GAEM_MODE_TWO;
	wire logic live = atn_cmd_valid && !pon_ff;

	wire logic hit_mta = live && bus_cmd == major_talk && !first_internal_address_ff.talk_dis;
	wire logic hit_mla = live && bus_cmd == major_listen && !first_internal_address_ff.listen_dis;
	wire logic hit_minor_t = live && dual && bus_cmd == minor_talk
		&& !second_internal_address_ff.talk_dis;
	wire logic hit_sec_t = live && ext && talker_primary_addressed_state_ff && bus_cmd == sec_addr
		&& !second_internal_address_ff.talk_dis;
	wire logic hit_minor_l = live && dual && bus_cmd == minor_listen
		&& !second_internal_address_ff.listen_dis;
	wire logic hit_sec_l = live && ext && listener_primary_addressed_state_ff && bus_cmd == sec_addr
		&& !second_internal_address_ff.listen_dis;
	// a primary in extended mode only arms the secondary check
	wire logic set_talk   = (hit_mta && !ext) || hit_minor_t || hit_sec_t;
	wire logic set_listen = (hit_mla && !ext) || hit_minor_l || hit_sec_l;

	wire logic [7:0] eos_mask = auxiliary_register_a_ff.binary_length_select ?
		GAEM_EOS8_MASK : GAEM_EOS7_MASK;
	wire logic eos_rx_hit = ((data_in_byte ^ end_of_string_register_ff) & eos_mask) == 8'h00;
	wire logic eos_tx_hit =
		((command_data_out_register ^ end_of_string_register_ff) & eos_mask) == 8'h00;

	// address registers; contents undefined at reset, held at zero here
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			first_internal_address_ff  <= '0;
			second_internal_address_ff <= '0;
		end else begin
			if (wr_first) begin
				first_internal_address_ff.talk_dis   <= reg_wdata[GAEM_DT_BIT];
				first_internal_address_ff.listen_dis <= reg_wdata[GAEM_DL_BIT];
				first_internal_address_ff.addr <= reg_wdata[4:0];
			end
			if (wr_second) begin
				second_internal_address_ff.talk_dis   <= reg_wdata[GAEM_DT_BIT];
				second_internal_address_ff.listen_dis <= reg_wdata[GAEM_DL_BIT];
				second_internal_address_ff.addr       <= reg_wdata[4:0];
			end
			// eoi clear; a new byte wins
			if (chip_reset || pon_ff)
				second_internal_address_ff.flag <= 1'b0;
			if (byte_accepted)
				second_internal_address_ff.flag <= eoi_line;
		end
	end

	// eos byte and auxiliary register a
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			end_of_string_register_ff <= 8'h00;
			auxiliary_register_a_ff   <= '0;
		end else begin
			if (wr_eos)
				end_of_string_register_ff <= reg_wdata;
			// chip reset also clears aux a
			if (chip_reset)
				auxiliary_register_a_ff <= '0;
			else if (aux_a_wr && !pon_ff)
				auxiliary_register_a_ff <= aux_a_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			pon_ff <= 1'b1;
		// chip reset sets, pon command clears
		else if (chip_reset)
			pon_ff <= 1'b1;
		else if (pon_clear)
			pon_ff <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (sys_rst || chip_reset)
			icr_ff <= GAEM_ICR_RESET;
	end

	// addressed states; talker and listener exclude each other
	always_ff @(posedge clock) begin
		if (sys_rst || pon_ff) begin
			talker_primary_addressed_state_ff   <= 1'b0;
			listener_primary_addressed_state_ff   <= 1'b0;
			talk_ff   <= 1'b0;
			listen_ff <= 1'b0;
		end else if (live) begin
			talker_primary_addressed_state_ff <= hit_mta;
			listener_primary_addressed_state_ff <= hit_mla;
			if (set_talk) begin
				talk_ff   <= 1'b1;
				listen_ff <= 1'b0;
			end else if (set_listen) begin
				listen_ff <= 1'b1;
				talk_ff   <= 1'b0;
			end
		end
	end

	// readback: first at address offset, second at eos offset
	always_comb begin
		reg_rdata = 8'h00;
		if (hit_addr)
			reg_rdata = first_internal_address_ff;
		else if (hit_eos)
			reg_rdata = second_internal_address_ff;
	end

	// first register serves every mode as primary/major
	assign talker_primary_addressed_state   = talker_primary_addressed_state_ff;
	assign listener_primary_addressed_state = listener_primary_addressed_state_ff;
	assign talk_addressed   = talk_ff;
	assign listen_addressed = listen_ff;
	assign end_flag_set = listener_active && auxiliary_register_a_ff.end_on_eos_received
		&& byte_accepted && eos_rx_hit;
	// eoi low on matching output byte
	assign eoi_out_n = !(talker_active && auxiliary_register_a_ff.transmit_end_with_eos
		&& eos_tx_hit);
	assign aux_cmd_exec = aux_ok;
	assign power_on = pon_ff;
	assign internal_counter_register = icr_ff;
endmodule : gaem_match
`default_nettype wire

// ---- test/gaem_match_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module gaem_match_props
	import gaem_pkg::*;
(
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       aux_cmd_valid,
	input wire logic [7:0] aux_cmd,
	input wire logic       byte_accepted,
	input wire logic       listener_active,
	input wire logic       talker_active,
	input wire logic       eoi_out_n,
	input wire logic       end_flag_set,
	input wire logic       talk_addressed,
	input wire logic       power_on,
	input wire logic       aux_cmd_exec,
	input wire logic [3:0] internal_counter_register
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// write to the first register, then read it back
	sequence s_wr_first;
		reg_wr && reg_addr == GAEM_OFS_ADDR_A && !reg_wdata[GAEM_SEL_BIT];
	endsequence
	sequence s_rd_first;
		reg_addr == GAEM_OFS_ADDR_A;
	endsequence
	a_ctr_reset_eight: assert property (
		$past(sys_rst) |-> internal_counter_register == GAEM_ICR_RESET)
		else $error("counter not eight after reset");
	a_write_first: assert property (
		s_wr_first ##1 s_rd_first |-> reg_rdata[6:0] == $past(reg_wdata[6:0]))
		else $error("first address register not loaded");
	a_pon_release: assert property (
		aux_cmd_valid && aux_cmd == GAEM_CMD_PON_CLEAR |=> !power_on)
		else $error("power-on not released");
	a_chip_reset_pon: assert property (
		aux_cmd_valid && aux_cmd == GAEM_CMD_CHIP_RESET && !power_on |=> power_on)
		else $error("chip reset did not set power-on");
	a_aux_refused: assert property (power_on |-> !aux_cmd_exec)
		else $error("aux command ran under power-on");
	a_aux_accepted: assert property (
		aux_cmd_valid && !power_on |-> aux_cmd_exec)
		else $error("aux command not executed");
	a_eoi_talker: assert property (!eoi_out_n |-> talker_active)
		else $error("eoi driven while not talker");
	a_end_listener: assert property (
		end_flag_set |-> byte_accepted && listener_active)
		else $error("end flag without accepted byte");
	a_pon_no_talk: assert property (
		power_on && $past(power_on) |-> !talk_addressed)
		else $error("talker addressed under power-on");
endmodule : gaem_match_props
bind gaem_match gaem_match_props u_props (.*);
`default_nettype wire

// ---- test/gaem_bus_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module gaem_bus_peer (
	input  wire logic       clock,
	output logic            atn_cmd_valid,
	output logic            byte_accepted,
	output logic            eoi_line,
	output logic [7:0]      bus_cmd,
	output logic [7:0]      data_in_byte
);
	initial begin
		atn_cmd_valid = 0;
		byte_accepted = 0;
		eoi_line = 0;
		bus_cmd = 0;
		data_in_byte = 0;
	end
	// one byte from the bus: command under atn or data
	task automatic send(input logic atn, input logic [7:0] d, input logic e);
		@(negedge clock);
		atn_cmd_valid = atn;
		byte_accepted = !atn;
		bus_cmd = d;
		data_in_byte = d;
		eoi_line = e;
	endtask : send
	// released lines flip so a stale byte never looks valid
	task automatic idle;
		@(negedge clock);
		atn_cmd_valid = 0;
		byte_accepted = 0;
		bus_cmd = ~bus_cmd;
		data_in_byte = ~data_in_byte;
		eoi_line = ~eoi_line;
	endtask : idle
endmodule : gaem_bus_peer
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gaem_pkg::*;
	logic       clock = 0, sys_rst = 1, reg_wr = 0, aux_cmd_valid = 0, aux_a_wr = 0;
	logic       listener_active = 0, talker_active = 0, eoi_out_n, end_flag_set;
	logic       power_on, talk_addressed, listen_addressed, aux_cmd_exec;
	logic       talker_primary_addressed_state, listener_primary_addressed_state;
	logic       atn_cmd_valid, byte_accepted, eoi_line;
	logic [4:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, aux_cmd = 0, command_data_out_register = 0, reg_rdata;
	logic [7:0] bus_cmd, data_in_byte, d0, d1, eos;
	logic [3:0] internal_counter_register;
	gaem_aux_t  aux_a_wdata = '0;
	gaem_mode_t addressing_mode = GAEM_MODE_ONE;
	int         error_cnt = 0, n_checks = 0;
	gaem_match DUT (.*);
	gaem_bus_peer peer (.*);
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(logic [4:0] a, logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clock);
		reg_wr = 0;
	endtask : wr
	task automatic rd(logic [4:0] a, string n, logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		#1 chk(n, e, reg_rdata);
	endtask : rd
	task automatic aux(logic [7:0] c);
		@(negedge clock);
		aux_cmd = c;
		aux_cmd_valid = 1;
		@(negedge clock);
		aux_cmd_valid = 0;
	endtask : aux
	// command byte, answer one cycle later
	task automatic cmd(logic [7:0] c);
		peer.send(1, c, 0);
		peer.idle();
		#1;
	endtask : cmd
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial forever #2.5 clock = ~clock;
	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		complete_run();
	end
	initial begin
		void'($urandom(32'hA65E90F8));
		d0 = {1'b0, 2'($urandom), 5'($urandom_range(0, 30))};
		d1 = {2'b10, 1'($urandom), 5'($urandom_range(0, 30))};
		eos = 8'($urandom);
		repeat (5) @(negedge clock);
		sys_rst = 0;
		chk("icr", 8'h08, 8'(internal_counter_register));
		chk("pon", 8'h01, 8'(power_on));
		wr(GAEM_OFS_ADDR_A, d0);
		wr(GAEM_OFS_ADDR_A, d1);
		rd(GAEM_OFS_ADDR_A, "first_internal_address", d0);
		rd(GAEM_OFS_EOS_A, "second_internal_address", {1'b0, d1[6:0]});
		aux(GAEM_CMD_PON_CLEAR);
		chk("pon", 8'h00, 8'(power_on));
		cmd(GAEM_TALK_OFS + 8'(d0[4:0]));
		chk("talk", 8'(!d0[6]), 8'(talk_addressed));
		cmd(GAEM_LISTEN_OFS + 8'(d0[4:0]));
		chk("listen", 8'(!d0[5]), 8'(listen_addressed));
		cmd(8'h5F);
		cmd(GAEM_TALK_OFS + 8'(d1[4:0]));
		chk("minor", 8'h01, 8'(talk_addressed));
		// chip reset, then release, drops old addressing
		aux(GAEM_CMD_CHIP_RESET);
		aux(GAEM_CMD_PON_CLEAR);
		chk("talk_clr", 8'h00, 8'(talk_addressed));
		addressing_mode = GAEM_MODE_TWO;
		wr(GAEM_OFS_ADDR_A, {1'b1, d0[6:0]});
		cmd(8'h5F);
		cmd(GAEM_TALK_OFS + 8'(d0[4:0]));
		chk("talker_primary_addressed_state", 8'(!d0[6]), 8'(talker_primary_addressed_state));
		cmd(GAEM_SEC_OFS + 8'(d0[4:0]));
		chk("sec", 8'(!d0[6]), 8'(talk_addressed));
		wr(GAEM_OFS_EOS_A, eos);
		// seven and eight bit compare; bit 7 differs
		for (int b = 0; b < 2; b++) begin
			@(negedge clock);
			aux_a_wdata = {1'(b), 2'b11};
			aux_a_wr = 1;
			@(negedge clock);
			aux_a_wr = 0;
			listener_active = 1;
			peer.send(0, eos ^ 8'h80, 0);
			#1 chk("end", 8'(b == 0), 8'(end_flag_set));
			peer.idle();
			listener_active = 0;
			talker_active = 1;
			command_data_out_register = eos ^ 8'h80;
			#1 chk("eoi_out", 8'(b), 8'(eoi_out_n));
			talker_active = 0;
		end
		listener_active = 1;
		peer.send(0, eos, 1);
		peer.idle();
		rd(GAEM_OFS_EOS_A, "eoi", {1'b1, d0[6:0]});
		aux(GAEM_CMD_CHIP_RESET);
		rd(GAEM_OFS_EOS_A, "eoi", {1'b0, d0[6:0]});
		chk("pon", 8'h01, 8'(power_on));
		complete_run();
	end
endmodule : testbench
`default_nettype wire
